// [src/stim2r_pkg.sv]
// constants, types and decode helpers for the stimulus-two response registers
// assumes register accesses arrive from the management port on the same clock
package stim2r_pkg;

    // register offsets on the management port
    localparam logic [7:0] STIM2R_RESP_OFS = 8'h36;
    localparam logic [7:0] STIM2R_PDTH_OFS = 8'h37;
    localparam logic [7:0] STIM2R_RATIO_OFS = 8'h38;

    // power-on values
    localparam logic [7:0] STIM2R_RESP_RST = 8'h09;
    localparam logic [7:0] STIM2R_PDTH_RST = 8'h00;
    localparam logic [7:0] STIM2R_RATIO_RST = 8'h04;

    // field positions
    localparam int STIM2R_MAG_LSB = 4;
    localparam int STIM2R_TYPE_LSB = 0;
    localparam int STIM2R_PD_LSB = 4;
    localparam int STIM2R_TH_LSB = 0;
    localparam int STIM2R_RATIO_LSB = 0;

    // codes that may not be stored
    localparam logic [3:0] STIM2R_MAG_BAD = 4'hf;
    localparam logic [3:0] STIM2R_TH_BAD = 4'hf;
    localparam logic [2:0] STIM2R_RATIO_BAD = 3'h7;

    // stimulus selections driven by bus voltage
    localparam logic [2:0] STIM2R_SEL_VBUS_READY = 3'h0;
    localparam logic [2:0] STIM2R_SEL_VBUS_ON = 3'h7;

    typedef enum logic [3:0] {
        RT_REMOVE = 4'h0,
        RT_V_DP = 4'h1,
        RT_V_DM = 4'h2,
        RT_V_BOTH = 4'h3,
        RT_R_DP = 4'h4,
        RT_BAD5 = 4'h5,
        RT_DIV_DP = 4'h6,
        RT_R_DM = 4'h7,
        RT_BAD8 = 4'h8,
        RT_DIV_DM = 4'h9,
        RT_SHORT = 4'ha,
        RT_BADB = 4'hb,
        RT_DIV_BOTH = 4'hc,
        RT_R_BOTH = 4'hd,
        RT_PD_KEEP = 4'he,
        RT_PD_KEEP2 = 4'hf
    } stim2r_rtype_t;

    // what one data-line pin carries, one-hot
    typedef enum logic [4:0] {
        PIN_PD15K = 5'h01,
        PIN_OPEN = 5'h02,
        PIN_VOLT = 5'h04,
        PIN_RES = 5'h08,
        PIN_DIV = 5'h10
    } stim2r_pin_t;

    // shared millivolt ladder of magnitude and threshold codes
    function automatic logic [11:0] stim2r_mv(input logic [3:0] c);
        if (c <= 4'h4) begin
            return 12'h190;
        end else if (c <= 4'h9) begin
            return 12'(c) * 12'h064;
        end else if (c != 4'hf) begin
            return 12'(c) * 12'h0c8 - 12'h258;
        end
        return 12'h000;
    endfunction

endpackage

// [src/stim2r_decode.sv]
// turns the stored codes into physical values: mV, 100-ohm units, kohm, percent, uA
// assumes only valid codes are ever presented; bad codes decode to zero
`timescale 1ns/1ps
module stim2r_decode
    import stim2r_pkg::*;
(
    input wire logic [3:0] mag_i,
    input wire logic [3:0] thr_i,
    input wire logic [2:0] ratio_i,
    input wire logic [1:0] pd_i,
    output logic [11:0] volt_mv_o,
    output logic [10:0] res_o,
    output logic [7:0] div_o,
    output logic [6:0] ratio_o,
    output logic [7:0] pd_o,
    output logic [11:0] thr_o
);

    always_comb begin
        volt_mv_o = (mag_i == 4'h0) ? 12'h000 : stim2r_mv(mag_i);
        thr_o = (thr_i == 4'h3) ? 12'h12c : stim2r_mv(thr_i);
        case (mag_i)
            4'h0: res_o = 11'h012;
            4'h1: res_o = 11'h064;
            4'h2: res_o = 11'h096;
            4'h3: res_o = 11'h0c8;
            4'h4: res_o = 11'h0fa;
            4'h5: res_o = 11'h12c;
            4'h6: res_o = 11'h190;
            4'h7: res_o = 11'h1ae;
            4'h8: res_o = 11'h1f4;
            4'h9: res_o = 11'h258;
            4'ha: res_o = 11'h2ee;
            4'hb: res_o = 11'h320;
            4'hc: res_o = 11'h3e8;
            4'hd: res_o = 11'h4b0;
            4'he: res_o = 11'h5dc;
            default: res_o = 11'h000;
        endcase
        if (mag_i == 4'hf) begin
            div_o = 8'h00;
        end else if (mag_i[2]) begin
            div_o = 8'hc8;
        end else begin
            case (mag_i[1:0])
                2'h0: div_o = 8'h5d;
                2'h1: div_o = 8'h64;
                2'h2: div_o = 8'h7d;
                default: div_o = 8'h96;
            endcase
        end
        case (ratio_i)
            3'h0: ratio_o = 7'h19;
            3'h1: ratio_o = 7'h21;
            3'h2: ratio_o = 7'h28;
            3'h3: ratio_o = 7'h32;
            3'h4: ratio_o = 7'h36;
            3'h5: ratio_o = 7'h3c;
            3'h6: ratio_o = 7'h42;
            default: ratio_o = 7'h00;
        endcase
        case (pd_i)
            2'h0: pd_o = 8'h0a;
            2'h1: pd_o = 8'h32;
            2'h2: pd_o = 8'h64;
            default: pd_o = 8'h96;
        endcase
    end

endmodule // stim2r_decode

// [src/stim2r_regs.sv]
// stimulus-two response configuration registers and the pin response they drive
// assumes register strobes, stimulus select and event pulses come from logic on MCLK_I
//
// What this block does
// - response register: magnitude high, type low, 0x09
// - writes of not-for-use codes leave field unchanged
// - types 0000-0011 use magnitude as voltage
// - voltage ladder: pull-down, 400 to 2200 mV
// - resistor types decode magnitude 1.8k to 150k
// - divider types decode minimum total resistance
// - types 0000-0011 remove or apply voltage
// - resistor, divider, short and both-pin resistor types
// - types 1110/1111 keep or drop reset pull-downs
// - untouched pin keeps pull-down only for 000, except types 1110/1111, which drop it only for 111
// - pull-down field selects 10 to 150 uA
// - threshold ladder 300 to 2200 mV
// - threshold ignored for selections 000 and 111
// - pull-down and threshold frozen during legacy profiles
// - pull-down bits 5-4, threshold bits 3-0
// - ratio field 0.25 to 0.66, 111 refused
// - selections 000/111 do not wait for removal
`timescale 1ns/1ps
module stim2r_regs
    import stim2r_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [2:0] SECOND_STIMULUS_SELECT_I,
    input wire logic STIM_HIT_I,
    input wire logic EMU_RESET_I,
    input wire logic EMULATION_CYCLE_LEGACY_I,
    output logic [7:0] REG_RDATA_O,
    output logic [4:0] DATA_PLUS_PORT_PIN_MODE_O,
    output logic [4:0] DATA_MINUS_PORT_PIN_MODE_O,
    output logic PIN_SHORT_O,
    output logic [11:0] VOLT_MV_O,
    output logic [10:0] RES_X100_O,
    output logic [7:0] DIV_KOHM_O,
    output logic [6:0] RATIO_PCT_O,
    output logic [7:0] PULLDOWN_UA_O,
    output logic [11:0] THRESHOLD_MV_O,
    output logic THRESHOLD_USE_O,
    output logic NO_WAIT_O
);

    typedef struct packed {
        logic [3:0] mag;
        stim2r_rtype_t rtype;
        logic [1:0] pd;
        logic [3:0] thr;
        logic [2:0] ratio;
        stim2r_pin_t dp;
        stim2r_pin_t dm;
        logic short_en;
        logic [11:0] volt_mv;
        logic [10:0] res;
        logic [7:0] div_k;
        logic [6:0] ratio_pct;
        logic [7:0] pd_ua;
        logic [11:0] thr_mv;
        logic thr_use;
        logic no_wait;
        logic [7:0] rdata;
    } stim2r_state_t;

    localparam stim2r_state_t STATE_RST = '{
        mag: STIM2R_RESP_RST[7:4],
        rtype: stim2r_rtype_t'(STIM2R_RESP_RST[3:0]),
        pd: STIM2R_PDTH_RST[5:4],
        thr: STIM2R_PDTH_RST[3:0],
        ratio: STIM2R_RATIO_RST[2:0],
        dp: PIN_OPEN,
        dm: PIN_OPEN,
        short_en: 1'b0,
        volt_mv: 12'h000,
        res: 11'h000,
        div_k: 8'h00,
        ratio_pct: 7'h00,
        pd_ua: 8'h00,
        thr_mv: 12'h000,
        thr_use: 1'b0,
        no_wait: 1'b0,
        rdata: 8'h00
    };

    stim2r_state_t q;
    stim2r_state_t d;

    logic [11:0] dec_volt;
    logic [10:0] dec_res;
    logic [7:0] dec_div;
    logic [6:0] dec_ratio;
    logic [7:0] dec_pd;
    logic [11:0] dec_thr;

    // response types with no defined action
    function automatic logic type_ok(input logic [3:0] t);
        return !(t == RT_BAD5 || t == RT_BAD8 || t == RT_BADB);
    endfunction

    function automatic logic sel_is_vbus(input logic [2:0] s);
        return s == STIM2R_SEL_VBUS_READY || s == STIM2R_SEL_VBUS_ON;
    endfunction

    // a pin the response does not name keeps what it had, except that the
    // reset pull-down only survives a ready-voltage stimulus
    function automatic stim2r_pin_t leave_pin(input stim2r_pin_t p, input logic keep);
        return (p == PIN_PD15K && !keep) ? PIN_OPEN : p;
    endfunction

    stim2r_decode u_decode (
        .mag_i(q.mag),
        .thr_i(q.thr),
        .ratio_i(q.ratio),
        .pd_i(q.pd),
        .volt_mv_o(dec_volt),
        .res_o(dec_res),
        .div_o(dec_div),
        .ratio_o(dec_ratio),
        .pd_o(dec_pd),
        .thr_o(dec_thr)
    );

    always_comb begin
        logic keep_pd;
        logic [3:0] w_mag;
        logic [3:0] w_type;
        d = q;
        keep_pd = SECOND_STIMULUS_SELECT_I == STIM2R_SEL_VBUS_READY;
        w_mag = REG_WDATA_I[STIM2R_MAG_LSB +: 4];
        w_type = REG_WDATA_I[STIM2R_TYPE_LSB +: 4];

        if (REG_RD_I) begin
            case (REG_ADDR_I)
                STIM2R_RESP_OFS: d.rdata = {q.mag, q.rtype};
                STIM2R_PDTH_OFS: d.rdata = {2'b00, q.pd, q.thr};
                STIM2R_RATIO_OFS: d.rdata = {5'h00, q.ratio};
                default: d.rdata = 8'h00;
            endcase
        end

        // each field is judged alone, so one bad field does not block the other
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                STIM2R_RESP_OFS: begin
                    if (w_mag != STIM2R_MAG_BAD) begin
                        d.mag = w_mag;
                    end
                    if (type_ok(w_type)) begin
                        d.rtype = stim2r_rtype_t'(w_type);
                    end
                end
                STIM2R_PDTH_OFS: begin
                    d.pd = REG_WDATA_I[STIM2R_PD_LSB +: 2];
                    if (REG_WDATA_I[STIM2R_TH_LSB +: 4] != STIM2R_TH_BAD) begin
                        d.thr = REG_WDATA_I[STIM2R_TH_LSB +: 4];
                    end
                end
                STIM2R_RATIO_OFS: begin
                    if (REG_WDATA_I[STIM2R_RATIO_LSB +: 3] != STIM2R_RATIO_BAD) begin
                        d.ratio = REG_WDATA_I[STIM2R_RATIO_LSB +: 3];
                    end
                end
                default: ;
            endcase
        end

        d.thr_use = !sel_is_vbus(SECOND_STIMULUS_SELECT_I);
        d.no_wait = sel_is_vbus(SECOND_STIMULUS_SELECT_I);

        if (!EMULATION_CYCLE_LEGACY_I) begin
            d.pd_ua = dec_pd;
            d.thr_mv = dec_thr;
        end

        if (EMU_RESET_I) begin
            d.dp = PIN_PD15K;
            d.dm = PIN_PD15K;
            d.short_en = 1'b0;
        end else if (STIM_HIT_I) begin
            d.volt_mv = dec_volt;
            d.res = dec_res;
            d.div_k = dec_div;
            d.ratio_pct = dec_ratio;
            case (q.rtype)
                RT_REMOVE: begin
                    d.dp = PIN_OPEN;
                    d.dm = PIN_OPEN;
                    d.short_en = 1'b0;
                end
                RT_V_DP: begin
                    d.dp = PIN_VOLT;
                    d.dm = leave_pin(q.dm, keep_pd);
                end
                RT_V_DM: begin
                    d.dm = PIN_VOLT;
                    d.dp = leave_pin(q.dp, keep_pd);
                end
                RT_V_BOTH: begin
                    d.dp = PIN_VOLT;
                    d.dm = PIN_VOLT;
                end
                RT_R_DP: begin
                    d.dp = PIN_RES;
                    d.dm = leave_pin(q.dm, keep_pd);
                end
                RT_R_DM: begin
                    d.dm = PIN_RES;
                    d.dp = leave_pin(q.dp, keep_pd);
                end
                RT_DIV_DP: begin
                    d.dp = PIN_DIV;
                    d.dm = leave_pin(q.dm, keep_pd);
                end
                RT_DIV_DM: begin
                    d.dm = PIN_DIV;
                    d.dp = leave_pin(q.dp, keep_pd);
                end
                RT_DIV_BOTH: begin
                    d.dp = PIN_DIV;
                    d.dm = PIN_DIV;
                end
                RT_R_BOTH: begin
                    d.dp = PIN_RES;
                    d.dm = PIN_RES;
                end
                RT_SHORT: begin
                    d.short_en = 1'b1;
                    d.dp = leave_pin(q.dp, keep_pd);
                    d.dm = leave_pin(q.dm, keep_pd);
                end
                RT_PD_KEEP, RT_PD_KEEP2: begin
                    if (SECOND_STIMULUS_SELECT_I == STIM2R_SEL_VBUS_ON) begin
                        d.dp = leave_pin(q.dp, 1'b0);
                        d.dm = leave_pin(q.dm, 1'b0);
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA_O = q.rdata;
    assign DATA_PLUS_PORT_PIN_MODE_O = q.dp;
    assign DATA_MINUS_PORT_PIN_MODE_O = q.dm;
    assign PIN_SHORT_O = q.short_en;
    assign VOLT_MV_O = q.volt_mv;
    assign RES_X100_O = q.res;
    assign DIV_KOHM_O = q.div_k;
    assign RATIO_PCT_O = q.ratio_pct;
    assign PULLDOWN_UA_O = q.pd_ua;
    assign THRESHOLD_MV_O = q.thr_mv;
    assign THRESHOLD_USE_O = q.thr_use;
    assign NO_WAIT_O = q.no_wait;

    AST_RESP_POR: assert property (@(posedge MCLK_I)
        RST_I |=> {q.mag, q.rtype} == 8'h09 && q.pd == 2'h0 && q.thr == 4'h0 && q.ratio == 3'h4)
        else $error("response register power-on value wrong");

    AST_MAG_REFUSE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REG_WR_I && REG_ADDR_I == STIM2R_RESP_OFS && REG_WDATA_I[7:4] == 4'hf
        |=> $stable(q.mag))
        else $error("not-for-use magnitude was stored");

    AST_TYPE_REFUSE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REG_WR_I && REG_ADDR_I == STIM2R_RESP_OFS && !type_ok(REG_WDATA_I[3:0])
        |=> $stable(q.rtype))
        else $error("undefined response type was stored");

    AST_TYPE_TAKE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REG_WR_I && REG_ADDR_I == STIM2R_RESP_OFS && REG_WDATA_I[7:4] != 4'hf
        && type_ok(REG_WDATA_I[3:0]) ##1 !REG_WR_I ##1 REG_RD_I && REG_ADDR_I == STIM2R_RESP_OFS
        |=> REG_RDATA_O == $past(REG_WDATA_I, 3))
        else $error("valid response write not read back");

    AST_VOLT_DP: assert property (@(posedge MCLK_I) disable iff (RST_I)
        STIM_HIT_I && !EMU_RESET_I && q.rtype == RT_V_DP
        |=> DATA_PLUS_PORT_PIN_MODE_O == PIN_VOLT && VOLT_MV_O == $past(dec_volt))
        else $error("voltage response not applied on plus pin");

    AST_DIV_BOTH: assert property (@(posedge MCLK_I) disable iff (RST_I)
        STIM_HIT_I && !EMU_RESET_I && q.rtype == RT_DIV_BOTH
        |=> DATA_PLUS_PORT_PIN_MODE_O == PIN_DIV && DATA_MINUS_PORT_PIN_MODE_O == PIN_DIV)
        else $error("divider not placed on both pins");

    AST_PD_KEEP: assert property (@(posedge MCLK_I) disable iff (RST_I)
        STIM_HIT_I && !EMU_RESET_I && q.rtype[3:1] == 3'h7 && q.dp == PIN_PD15K && q.dm == PIN_PD15K
        && SECOND_STIMULUS_SELECT_I == 3'h0
        |=> DATA_PLUS_PORT_PIN_MODE_O == PIN_PD15K && DATA_MINUS_PORT_PIN_MODE_O == PIN_PD15K)
        else $error("reset pull-downs dropped for ready selection");

    AST_OTHER_PIN: assert property (@(posedge MCLK_I) disable iff (RST_I)
        STIM_HIT_I && !EMU_RESET_I && q.rtype == RT_V_DP && q.dm == PIN_PD15K
        && SECOND_STIMULUS_SELECT_I != 3'h0
        |=> DATA_MINUS_PORT_PIN_MODE_O == PIN_OPEN)
        else $error("untouched pin pull-down not removed");

    AST_THR_IGNORE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        SECOND_STIMULUS_SELECT_I == 3'h7 |=> !THRESHOLD_USE_O && NO_WAIT_O)
        else $error("threshold used for bus-voltage selection");

    AST_LEGACY_HOLD: assert property (@(posedge MCLK_I) disable iff (RST_I)
        EMULATION_CYCLE_LEGACY_I [*2] |-> $stable(PULLDOWN_UA_O) && $stable(THRESHOLD_MV_O))
        else $error("pull-down or threshold refreshed in legacy profile");

    AST_PDTH_UNUSED: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REG_RD_I && REG_ADDR_I != STIM2R_RESP_OFS |=> REG_RDATA_O[7:6] == 2'b00)
        else $error("unimplemented bits read non-zero");

    AST_RATIO_REFUSE: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REG_WR_I && REG_ADDR_I == STIM2R_RATIO_OFS && REG_WDATA_I[2:0] == 3'h7
        |=> q.ratio == $past(q.ratio))
        else $error("ratio 111 was stored");

endmodule // stim2r_regs

// [verif/stim2r_portable_model.sv]
// portable-device model on the far side of the data lines
// assumes the bench asks for a stimulus by a one-cycle touch request on MCLK_I
`timescale 1ns/1ps
module stim2r_portable_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic touch_i,
    input wire logic slow_i,
    output logic hit_o
);
    logic [2:0] stage_q;

    // a slow device answers two cycles later; either way the detect is one cycle wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= 3'h0;
        end else begin
            stage_q <= {stage_q[1:0], touch_i};
        end
    end
    assign hit_o = slow_i ? stage_q[2] : stage_q[0];
endmodule // stim2r_portable_model

// [verif/stim2r_regs_tb.sv]
// self-checking bench for the stimulus-two response registers
// assumes the portable-device model raises the stimulus and the bench owns the register port
`timescale 1ns/1ps
module stim2r_regs_tb;
    import stim2r_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] sel = 3'h2;
    logic touch = 1'b0;
    logic slow = 1'b0;
    logic emu = 1'b0;
    logic legacy = 1'b0;
    logic hit;
    logic [7:0] rdata;
    logic [4:0] dp;
    logic [4:0] dm;
    logic shorted;
    logic [11:0] volt;
    logic [10:0] res;
    logic [7:0] div;
    logic [6:0] ratio;
    logic [7:0] pd_ua;
    logic [11:0] thr_mv;
    logic thr_use;
    logic no_wait;
    int err_count = 0;
    int n_checks = 0;
    // resistor in 100-ohm units, divider kohm, ratio hundredths, sink uA
    logic [10:0] res_tab [15] = '{11'h012, 11'h064, 11'h096, 11'h0c8, 11'h0fa, 11'h12c, 11'h190, 11'h1ae,
        11'h1f4, 11'h258, 11'h2ee, 11'h320, 11'h3e8, 11'h4b0, 11'h5dc};
    logic [7:0] div_tab [4] = '{8'h5d, 8'h64, 8'h7d, 8'h96};
    logic [6:0] rat_tab [7] = '{7'h19, 7'h21, 7'h28, 7'h32, 7'h36, 7'h3c, 7'h42};
    logic [7:0] ua_tab [4] = '{8'h0a, 8'h32, 8'h64, 8'h96};
    // select, type, plus and minus pin as one-hot bit index, short
    logic [19:0] pin_tab [16] = '{20'h20110, 20'h21210, 20'h22120, 20'h23220, 20'h24310, 20'h26410,
        20'h27130, 20'h29140, 20'h2a111, 20'h2c440, 20'h2d330, 20'h01200, 20'h0e000, 20'h7f110,
        20'h2e000, 20'h07030};

    always #5 clk = ~clk;

    stim2r_portable_model i_dev (.clk_i(clk), .rst_i(rst), .touch_i(touch), .slow_i(slow), .hit_o(hit));

    stim2r_regs i_dut (.MCLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .SECOND_STIMULUS_SELECT_I(sel), .STIM_HIT_I(hit),
        .EMU_RESET_I(emu), .EMULATION_CYCLE_LEGACY_I(legacy), .REG_RDATA_O(rdata),
        .DATA_PLUS_PORT_PIN_MODE_O(dp), .DATA_MINUS_PORT_PIN_MODE_O(dm), .PIN_SHORT_O(shorted),
        .VOLT_MV_O(volt), .RES_X100_O(res), .DIV_KOHM_O(div), .RATIO_PCT_O(ratio),
        .PULLDOWN_UA_O(pd_ua), .THRESHOLD_MV_O(thr_mv), .THRESHOLD_USE_O(thr_use), .NO_WAIT_O(no_wait));

    function automatic logic [15:0] mv(input logic [3:0] c, input logic thr);
        if (thr && c == 4'h3) return 16'h012c;
        if (!thr && c == 4'h0) return 16'h0000;
        if (c <= 4'h4) return 16'h0190;
        if (c <= 4'h9) return 16'(c) * 16'h0064;
        return 16'h0578 + 16'(c - 4'ha) * 16'h00c8;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask

    task automatic emu_pulse();
        @(posedge clk);
        emu <= 1'b1;
        @(posedge clk);
        emu <= 1'b0;
        #1;
    endtask

    // the device may answer late, so wait for its detect under a bound
    task automatic hit_pulse();
        int n;
        @(posedge clk);
        touch <= 1'b1;
        @(posedge clk);
        touch <= 1'b0;
        n = 0;
        while (hit !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n < 8), 16'h0001);
        #1;
    endtask

    task automatic t_reset();
        rdc(8'h36, 8'h09);
        rdc(8'h37, 8'h00);
        rdc(8'h38, 8'h04);
        chk(16'(dp), 16'(PIN_OPEN));
        chk(16'(shorted), 16'h0000);
        emu_pulse();
        chk(16'(dm), 16'(PIN_PD15K));
    endtask

    task automatic t_refuse();
        logic [3:0] bad [3] = '{4'h5, 4'h8, 4'hb};
        wr(8'h36, 8'h5a);
        rdc(8'h36, 8'h5a);
        wr(8'h36, 8'hf1);
        rdc(8'h36, 8'h51);
        for (int i = 0; i < 3; i++) begin
            wr(8'h36, {4'h3, bad[i]});
            rdc(8'h36, 8'h31);
        end
        wr(8'h37, 8'he5);
        rdc(8'h37, 8'h25);
        wr(8'h37, 8'hff);
        rdc(8'h37, 8'h35);
        wr(8'h38, 8'hfb);
        rdc(8'h38, 8'h03);
        wr(8'h38, 8'hff);
        rdc(8'h38, 8'h03);
        wr(8'h40, 8'hff);
        rdc(8'h40, 8'h00);
    endtask

    task automatic t_pins();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            sel <= pin_tab[i][18:16];
            emu_pulse();
            wr(8'h36, {4'h2, pin_tab[i][15:12]});
            hit_pulse();
            chk(16'(dp), 16'(5'h01 << pin_tab[i][11:8]));
            chk(16'(dm), 16'(5'h01 << pin_tab[i][7:4]));
            chk(16'(shorted), 16'(pin_tab[i][0]));
        end
        // a single-pin response leaves the other pin's earlier response in place
        @(posedge clk);
        sel <= 3'h2;
        emu_pulse();
        wr(8'h36, 8'h21);
        hit_pulse();
        wr(8'h36, 8'h22);
        hit_pulse();
        chk(16'(dp), 16'(PIN_VOLT));
    endtask

    task automatic t_magnitudes();
        for (int c = 0; c < 15; c++) begin
            wr(8'h36, {c[3:0], 4'h1});
            hit_pulse();
            chk(16'(volt), mv(c[3:0], 1'b0));
            chk(16'(dp), 16'(PIN_VOLT));
            wr(8'h36, {c[3:0], 4'h4});
            hit_pulse();
            chk(16'(res), 16'(res_tab[c]));
            wr(8'h36, {c[3:0], 4'h9});
            hit_pulse();
            chk(16'(div), c[2] ? 16'h00c8 : 16'(div_tab[c[1:0]]));
        end
    endtask

    task automatic t_ratio();
        @(posedge clk);
        slow <= 1'b1;
        wr(8'h36, 8'h0c);
        for (int c = 0; c < 7; c++) begin
            wr(8'h38, {5'h00, c[2:0]});
            hit_pulse();
            chk(16'(ratio), 16'(rat_tab[c]));
        end
        @(posedge clk);
        slow <= 1'b0;
    endtask

    task automatic t_thresh();
        for (int c = 0; c < 15; c++) begin
            wr(8'h37, {2'b00, c[1:0], c[3:0]});
            @(posedge clk);
            #1;
            chk(16'(pd_ua), 16'(ua_tab[c[1:0]]));
            chk(16'(thr_mv), mv(c[3:0], 1'b1));
        end
    endtask

    // legacy profiles must not see the pull-down and threshold move under them
    task automatic t_legacy();
        wr(8'h37, 8'h15);
        @(posedge clk);
        legacy <= 1'b1;
        wr(8'h37, 8'h3a);
        repeat (3) @(posedge clk);
        #1;
        chk(16'(pd_ua), 16'h0032);
        chk(16'(thr_mv), 16'h01f4);
        @(posedge clk);
        legacy <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(16'(thr_mv), 16'h0578);
    endtask

    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            sel <= s[2:0];
            @(posedge clk);
            #1;
            chk(16'(thr_use), 16'(s != 0 && s != 7));
            chk(16'(no_wait), 16'(s == 0 || s == 7));
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_refuse();
        t_pins();
        t_magnitudes();
        t_ratio();
        t_thresh();
        t_legacy();
        t_select();
        finish_test();
    end

    // the whole run needs under a thousand cycles; this is over thirty times that
    initial begin
        #300000;
        err_count++;
        finish_test();
    end
endmodule // stim2r_regs_tb
